//--- design/kea_pkg.sv
// Package: register map, field positions and constants of the emulated KBC.
package kea_pkg;
   // ========================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int EVT_W = 3;
   localparam int SYN_W = 13;
   // ========================================================
   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_AUX = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_SRC = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_EVT = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_GATE = 8'h20;
   // ========================================================
   // Keyboard control fields
   localparam int CTL_AUX_HW = 7;
   localparam int CTL_IRQ_EN = 5;
   localparam int CTL_OVERRIDE = 2;
   localparam int CTL_SW_ASSIST = 1;
   localparam logic [BYTE_W-1:0] CTL_USER_MASK = 8'h59;
   // ========================================================
   // Keyboard status fields
   localparam int ST_AUX_FULL = 5;
   localparam int ST_CMD_DATA = 3;
   localparam int ST_IBF_POS = 1;
   localparam int ST_OUT_FULL = 0;
   localparam logic [BYTE_W-1:0] ST_USER_MASK = 8'hD4;
   // ========================================================
   // Other fields
   localparam int SRC_BIT = 0;
   localparam int FW_GATE_BIT = 0;
   localparam int GATE_DATA_BIT = 1;
   localparam int EVT_HOST_READ = 0;
   localparam int EVT_HOST_WRITE = 1;
   localparam int EVT_GATE = 2;
   // Host pin positions in the synchroniser vector
   localparam int SYN_RD = 0;
   localparam int SYN_CMD = 1;
   localparam int SYN_DAT = 2;
   localparam int SYN_GHI = 3;
   localparam int SYN_GLO = 4;
   localparam int SYN_BYTE = 5;
   // ========================================================
   // Reset values
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [EVT_W-1:0] EVT_ZERO = 3'h0;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
endpackage

//--- design/kea_reg_if.sv
// Interface: decoded register access between the APB front and the core.
`timescale 1ns/100ps
`default_nettype none
interface kea_reg_if;
   import kea_pkg::*;
   logic wr;
   logic rd;
   logic [ADDR_W-1:0] addr;
   logic [BYTE_W-1:0] wdata;
   logic [BYTE_W-1:0] rdata;
   logic hit;
   modport front (output wr, output rd, output addr, output wdata,
                  input rdata, input hit);
   modport regs (input wr, input rd, input addr, input wdata,
                 output rdata, output hit);
endinterface
`default_nettype wire

//--- design/kea_sync.sv
// Module: two-flop synchroniser with rising-edge detect for host pins.
`timescale 1ns/100ps
`default_nettype none
module kea_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Pins and synchronised view
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~prev_q;
endmodule
`default_nettype wire

//--- design/kea_apb_front.sv
// Module: APB slave front end, one wait state, registered answer.
`timescale 1ns/100ps
`default_nettype none
module kea_apb_front
   import kea_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Register side
   kea_reg_if.front bus
);
   logic pready_q;
   logic pslverr_q;
   logic [DATA_W-1:0] prdata_q;
   logic first_access;
   logic done;

   assign first_access = psel_i & penable_i & ~pready_q;
   assign done = psel_i & penable_i & pready_q;

   // Read data caught in the first access cycle so it comes from a flop
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_ZERO;
      end else begin
         pready_q <= first_access;
         if (first_access) begin
            prdata_q <= {{(DATA_W-BYTE_W){1'b0}}, bus.rdata};
            pslverr_q <= ~bus.hit;
         end
      end
   end

   // Side effects happen only at the completing edge, unmapped ignored
   assign bus.wr = done & pwrite_i & bus.hit;
   assign bus.rd = done & ~pwrite_i & bus.hit;
   assign bus.addr = paddr_i;
   assign bus.wdata = pwdata_i[BYTE_W-1:0];
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
endmodule
`default_nettype wire

//--- design/kea_kbc_emulation_ctrl_aux.sv
// Top: emulated keyboard controller control, aux data and output-full source.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module kea_kbc_emulation_ctrl_aux
   import kea_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Host side strobes, from the LPC clock domain
   input wire logic host_read_i,
   input wire logic host_cmd_write_i,
   input wire logic host_data_write_i,
   input wire logic host_gate_high_i,
   input wire logic host_gate_low_i,
   input wire logic [BYTE_W-1:0] host_in_byte_i,
   // Host side outputs
   output logic [BYTE_W-1:0] host_out_byte_o,
   output logic [BYTE_W-1:0] host_status_o,
   output logic keyboard_host_irq_o,
   output logic mouse_host_irq_o,
   output logic address_line20_gate_o,
   // Firmware interrupt
   output logic irq_o
);
   // ========================================================
   // Decode helper
   function automatic logic is_off(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   // ========================================================
   // Bus front and host pin synchronisers
   kea_reg_if bus ();

   kea_apb_front u_front (
      .ref_clk_i (ref_clk_i),
      .rst_b_i (rst_b_i),
      .psel_i (psel_i),
      .penable_i (penable_i),
      .pwrite_i (pwrite_i),
      .paddr_i (paddr_i),
      .pwdata_i (pwdata_i),
      .prdata_o (prdata_o),
      .pready_o (pready_o),
      .pslverr_o (pslverr_o),
      .bus (bus.front)
   );

   logic [SYN_W-1:0] host_level;
   logic [SYN_W-1:0] host_rise;

   // The byte lanes only matter on a write strobe, which lags them
   kea_sync #(.W(SYN_W)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_b_i (rst_b_i),
      .async_i ({host_in_byte_i, host_gate_low_i, host_gate_high_i,
                 host_data_write_i, host_cmd_write_i, host_read_i}),
      .level_o (host_level),
      .rise_o (host_rise)
   );

   logic host_rd, host_cmd, host_dat, host_wr, host_ghi, host_glo;
   assign host_rd = host_rise[SYN_RD];
   assign host_cmd = host_rise[SYN_CMD];
   assign host_dat = host_rise[SYN_DAT];
   assign host_wr = host_cmd | host_dat;
   assign host_ghi = host_rise[SYN_GHI];
   assign host_glo = host_rise[SYN_GLO];

   // ========================================================
   // Access strobes
   logic wr_data, wr_status, wr_ctrl, wr_aux, wr_src;
   logic wr_evt, wr_mask, wr_gate, rd_data;
   assign wr_data = bus.wr & is_off(bus.addr, OFF_DATA);
   assign wr_status = bus.wr & is_off(bus.addr, OFF_STATUS);
   assign wr_ctrl = bus.wr & is_off(bus.addr, OFF_CTRL);
   assign wr_aux = bus.wr & is_off(bus.addr, OFF_AUX);
   assign wr_src = bus.wr & is_off(bus.addr, OFF_SRC);
   assign wr_evt = bus.wr & is_off(bus.addr, OFF_EVT);
   assign wr_mask = bus.wr & is_off(bus.addr, OFF_MASK);
   assign wr_gate = bus.wr & is_off(bus.addr, OFF_GATE);
   assign rd_data = bus.rd & is_off(bus.addr, OFF_DATA);

   // ========================================================
   // Registers
   logic [BYTE_W-1:0] ctrl_q, status_q, status_d, out_byte_q, in_byte_q;
   logic src_q, fw_gate_q, gate_q, kbd_irq_q, mouse_irq_q, irq_q, kbd_src;
   logic [EVT_W-1:0] evt_q, evt_d, mask_q;

   // Every control bit is plain storage; only four of them steer logic
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ctrl_q <= BYTE_ZERO;
      end else if (wr_ctrl) begin
         ctrl_q <= bus.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         src_q <= 1'b0;
         fw_gate_q <= 1'b0;
         mask_q <= EVT_ZERO;
      end else begin
         if (wr_src) begin
            src_q <= bus.wdata[SRC_BIT];
         end
         if (wr_gate) begin
            fw_gate_q <= bus.wdata[FW_GATE_BIT];
         end
         if (wr_mask) begin
            mask_q <= bus.wdata[EVT_W-1:0];
         end
      end
   end

   // Shared output byte: data and aux writes land in the same place
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         out_byte_q <= BYTE_ZERO;
      end else if (wr_data | wr_aux) begin
         out_byte_q <= bus.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         in_byte_q <= BYTE_ZERO;
      end else if (host_wr) begin
         in_byte_q <= host_level[SYN_BYTE +: BYTE_W];
      end
   end

   // ========================================================
   // Keyboard status; clears first so a same-cycle set wins
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = (status_q & ~ST_USER_MASK) | (bus.wdata & ST_USER_MASK);
         if (!ctrl_q[CTL_AUX_HW]) begin
            status_d[ST_AUX_FULL] = bus.wdata[ST_AUX_FULL];
         end
      end
      if (host_rd) begin
         status_d[ST_OUT_FULL] = 1'b0;
      end
      if (rd_data) begin
         status_d[ST_IBF_POS] = 1'b0;
      end
      if (host_cmd) begin
         status_d[ST_CMD_DATA] = 1'b1;
         status_d[ST_IBF_POS] = 1'b1;
      end
      if (host_dat) begin
         status_d[ST_CMD_DATA] = 1'b0;
         status_d[ST_IBF_POS] = 1'b1;
      end
      if (wr_aux) begin
         status_d[ST_CMD_DATA] = 1'b0;
         status_d[ST_IBF_POS] = 1'b1;
         status_d[ST_OUT_FULL] = 1'b1;
         if (ctrl_q[CTL_AUX_HW]) begin
            status_d[ST_AUX_FULL] = 1'b1;
         end
      end
      if (wr_data) begin
         status_d[ST_OUT_FULL] = 1'b1;
         status_d[ST_AUX_FULL] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         status_q <= BYTE_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   // ========================================================
   // Host interrupt lines
   // Changing the enable while output full would glitch the host line
   assign kbd_src = ctrl_q[CTL_OVERRIDE] ? src_q
                                         : status_q[ST_OUT_FULL];

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         kbd_irq_q <= 1'b0;
         mouse_irq_q <= 1'b0;
      end else begin
         kbd_irq_q <= ctrl_q[CTL_IRQ_EN] & kbd_src;
         mouse_irq_q <= ctrl_q[CTL_IRQ_EN] & status_q[ST_AUX_FULL];
      end
   end

   // ========================================================
   // Address line 20 gate
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         gate_q <= 1'b0;
      end else if (ctrl_q[CTL_SW_ASSIST]) begin
         gate_q <= fw_gate_q;
      end else if (wr_ctrl | wr_aux) begin
         gate_q <= bus.wdata[GATE_DATA_BIT];
      end else if (host_ghi) begin
         gate_q <= 1'b1;
      end else if (host_glo) begin
         gate_q <= 1'b0;
      end
   end

   // ========================================================
   // Firmware interrupt: sticky events, write one to clear
   always_comb begin
      evt_d = evt_q;
      if (wr_evt) begin
         evt_d = evt_q & ~bus.wdata[EVT_W-1:0];
      end
      if (host_rd) begin
         evt_d[EVT_HOST_READ] = 1'b1;
      end
      if (host_wr) begin
         evt_d[EVT_HOST_WRITE] = 1'b1;
      end
      if (host_ghi | host_glo) begin
         evt_d[EVT_GATE] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         evt_q <= EVT_ZERO;
         irq_q <= 1'b0;
      end else begin
         evt_q <= evt_d;
         irq_q <= |(evt_q & mask_q);
      end
   end

   // ========================================================
   // Read mux and address decode
   always_comb begin
      bus.hit = 1'b1;
      bus.rdata = BYTE_ZERO;
      if (is_off(bus.addr, OFF_DATA)) begin
         bus.rdata = in_byte_q;
      end else if (is_off(bus.addr, OFF_STATUS)) begin
         bus.rdata = status_q;
      end else if (is_off(bus.addr, OFF_CTRL)) begin
         bus.rdata = ctrl_q;
      end else if (is_off(bus.addr, OFF_AUX)) begin
         bus.rdata = BYTE_ZERO;
      end else if (is_off(bus.addr, OFF_SRC)) begin
         bus.rdata = {{(BYTE_W-1){1'b0}}, src_q};
      end else if (is_off(bus.addr, OFF_EVT)) begin
         bus.rdata = {{(BYTE_W-EVT_W){1'b0}}, evt_q};
      end else if (is_off(bus.addr, OFF_MASK)) begin
         bus.rdata = {{(BYTE_W-EVT_W){1'b0}}, mask_q};
      end else if (is_off(bus.addr, OFF_GATE)) begin
         bus.rdata = {{(BYTE_W-1){1'b0}}, fw_gate_q};
      end else begin
         bus.hit = 1'b0;
      end
   end

   assign host_out_byte_o = out_byte_q;
   assign host_status_o = status_q;
   assign keyboard_host_irq_o = kbd_irq_q;
   assign mouse_host_irq_o = mouse_irq_q;
   assign address_line20_gate_o = gate_q;
   assign irq_o = irq_q;

   // ========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   aux_hw_set_a: assert property (
      wr_aux && ctrl_q[CTL_AUX_HW] |=> status_q[ST_AUX_FULL])
      else $error("aux full not set by aux write in hardware mode");
   aux_sw_hold_a: assert property (
      !ctrl_q[CTL_AUX_HW] && !wr_status && !wr_data
      |=> $stable(status_q[ST_AUX_FULL]))
      else $error("aux full changed by hardware in software mode");
   host_irq_follow_a: assert property (
      ctrl_q[CTL_IRQ_EN] |=> keyboard_host_irq_o == $past(kbd_src)
      && mouse_host_irq_o == $past(status_q[ST_AUX_FULL]))
      else $error("host irq lines do not follow full flags");
   host_irq_low_a: assert property (
      !ctrl_q[CTL_IRQ_EN] |=> !keyboard_host_irq_o && !mouse_host_irq_o)
      else $error("host irq line high while disabled");
   src_override_a: assert property (
      wr_src ##1 (ctrl_q[CTL_OVERRIDE] && !wr_src)[*2]
      |-> kbd_src == $past(bus.wdata[SRC_BIT], 2))
      else $error("override source differs from written bit");
   src_track_a: assert property (
      wr_data && !ctrl_q[CTL_OVERRIDE] && !wr_ctrl |=> kbd_src)
      else $error("source does not track output full");
   gate_sw_a: assert property (
      ctrl_q[CTL_SW_ASSIST] |=> address_line20_gate_o == $past(fw_gate_q))
      else $error("gate not under firmware control");
   gate_host_a: assert property (
      !ctrl_q[CTL_SW_ASSIST] && host_ghi && !wr_ctrl && !wr_aux
      |=> address_line20_gate_o)
      else $error("gate ignored host control");
   aux_read_zero_a: assert property (
      bus.rd && is_off(bus.addr, OFF_AUX) |-> prdata_o == WORD_ZERO)
      else $error("aux data register read back a value");
   aux_flags_a: assert property (
      wr_aux |=> !status_q[ST_CMD_DATA] && status_q[ST_IBF_POS])
      else $error("aux write flags wrong");
   aux_byte_a: assert property (
      wr_aux |=> host_out_byte_o == $past(bus.wdata))
      else $error("host byte is not the aux byte");
   user_bits_a: assert property (
      wr_ctrl |=> (ctrl_q & CTL_USER_MASK)
      == ($past(bus.wdata) & CTL_USER_MASK))
      else $error("user control bits not stored");
   data_flags_a: assert property (
      wr_data |=> status_q[ST_OUT_FULL] && !status_q[ST_AUX_FULL])
      else $error("data write flags wrong");
   reset_clear_a: assert property (
      disable iff (1'b0) !rst_b_i |=> ctrl_q == BYTE_ZERO && !src_q
      && out_byte_q == BYTE_ZERO)
      else $error("reset left state behind");
endmodule
`default_nettype wire

//--- bench/kea_host_model.sv
// Host model: legacy host strobes and written byte, as the chipset side.
`timescale 1ns/100ps
`default_nettype none
module kea_host_model
   import kea_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Host strobes and byte
   output logic host_read_o,
   output logic host_cmd_write_o,
   output logic host_data_write_o,
   output logic host_gate_high_o,
   output logic host_gate_low_o,
   output logic [BYTE_W-1:0] host_byte_o
);
   logic [4:0] stb_q = 5'h00;
   logic [BYTE_W-1:0] byte_q = 8'hA5;

   assign host_read_o = stb_q[SYN_RD];
   assign host_cmd_write_o = stb_q[SYN_CMD];
   assign host_data_write_o = stb_q[SYN_DAT];
   assign host_gate_high_o = stb_q[SYN_GHI];
   assign host_gate_low_o = stb_q[SYN_GLO];
   assign host_byte_o = byte_q;

   // Byte held 4 clocks either side; strobe high 3, low long enough
   task automatic strobe(input int which, input logic [BYTE_W-1:0] b);
      @(posedge ref_clk_i);
      byte_q <= b;
      repeat (4) @(posedge ref_clk_i);
      stb_q[which] <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      stb_q[which] <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      // Released byte is not left showing the last value
      byte_q <= ~b;
      repeat (2) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: firmware over APB, host model on the legacy pins.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import kea_pkg::*;
;
   logic ref_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic h_rd, h_cmd, h_dat, h_ghi, h_glo, keyboard_host_irq, mouse_host_irq, gate, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic [BYTE_W-1:0] h_byte, out_byte, status, b;
   logic [32:0] q[$];
   int n_fail = 0;
   int num_checks = 0;
   int seed = 32'h41af_0389;

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   kea_kbc_emulation_ctrl_aux u_dut (.ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .host_read_i(h_rd), .host_cmd_write_i(h_cmd),
      .host_data_write_i(h_dat), .host_gate_high_i(h_ghi),
      .host_gate_low_i(h_glo), .host_in_byte_i(h_byte),
      .host_out_byte_o(out_byte), .host_status_o(status),
      .keyboard_host_irq_o(keyboard_host_irq), .mouse_host_irq_o(mouse_host_irq),
      .address_line20_gate_o(gate), .irq_o(irq));

   kea_host_model u_host (.ref_clk_i(ref_clk_i), .host_read_o(h_rd),
      .host_cmd_write_o(h_cmd), .host_data_write_o(h_dat),
      .host_gate_high_o(h_ghi), .host_gate_low_o(h_glo),
      .host_byte_o(h_byte));

   // ==========================================================
   // Reporting
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk_read(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: read %h want %h", $time, got, exp);
      end
   endtask

   task chk_out(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: pins %h want %h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // APB master
   task apb(input logic we, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
      int n;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         print_verdict();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask

   task rd(input logic [ADDR_W-1:0] a, input logic err,
           input logic [BYTE_W-1:0] e);
      q.push_back({err, 24'h00_0000, e});
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Irq outputs lag the register by one cycle, so wait three edges
   task look(input logic [7:0] st, input logic [3:0] pn);
      repeat (3) @(posedge ref_clk_i);
      chk_out(status, st);
      chk_out({4'h0, irq, mouse_host_irq, keyboard_host_irq, gate}, {4'h0, pn});
   endtask

   // Read answers are compared as they complete
   always @(posedge ref_clk_i) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (q.size() == 0)
            chk_read({pslverr, prdata}, 33'h1_ffff_ffff);
         else
            chk_read({pslverr, prdata}, q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      print_verdict();
   end

   // ==========================================================
   // Scenarios
   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      rst_b_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rd(OFF_CTRL, 1'b0, 8'h00);
      rd(OFF_SRC, 1'b0, 8'h00);
      rd(OFF_AUX, 1'b0, 8'h00);
      look(8'h00, 4'h0);
      rd(8'h10, 1'b1, 8'h00);
      b = 8'($random(seed)) & CTL_USER_MASK;
      wr(OFF_CTRL, b);
      rd(OFF_CTRL, 1'b0, b);
      look(8'h00, 4'h0);
      $display("test reset and storage done");
      u_host.strobe(SYN_CMD, b);
      look(8'h0A, 4'h0);
      // Firmware takes the host byte, which drops input full
      rd(OFF_DATA, 1'b0, b);
      rd(OFF_STATUS, 1'b0, 8'h08);
      wr(OFF_MASK, 8'h02);
      look(8'h08, 4'h8);
      wr(OFF_EVT, 8'h02);
      look(8'h08, 4'h0);
      $display("test interrupt done");
      // Output full is clear at every enable change below
      wr(OFF_CTRL, 8'hA0);
      b = 8'($random(seed));
      wr(OFF_AUX, b);
      look(8'h23, {3'b011, b[1]});
      rd(OFF_STATUS, 1'b0, 8'h23);
      chk_out(out_byte, b);
      rd(OFF_AUX, 1'b0, 8'h00);
      wr(OFF_DATA, 8'h5A);
      look(8'h03, {3'b001, b[1]});
      u_host.strobe(SYN_RD, 8'h00);
      look(8'h02, {3'b000, b[1]});
      $display("test aux hardware mode done");
      wr(OFF_CTRL, 8'h20);
      b = 8'($random(seed)) | 8'h02;
      wr(OFF_AUX, b);
      look(8'h03, 4'h3);
      wr(OFF_STATUS, 8'h20);
      look(8'h23, 4'h7);
      u_host.strobe(SYN_GLO, b);
      look(8'h23, 4'h6);
      u_host.strobe(SYN_RD, b);
      look(8'h22, 4'h4);
      wr(OFF_CTRL, 8'h24);
      wr(OFF_SRC, 8'h01);
      look(8'h22, 4'h6);
      rd(OFF_SRC, 1'b0, 8'h01);
      wr(OFF_DATA, 8'hC3);
      wr(OFF_SRC, 8'h00);
      look(8'h03, 4'h0);
      u_host.strobe(SYN_RD, b);
      $display("test override done");
      wr(OFF_CTRL, 8'h04);
      wr(OFF_SRC, 8'h01);
      wr(OFF_STATUS, 8'h20);
      look(8'h22, 4'h0);
      wr(OFF_CTRL, 8'h06);
      wr(OFF_GATE, 8'h01);
      u_host.strobe(SYN_GLO, b);
      look(8'h22, 4'h1);
      wr(OFF_GATE, 8'h00);
      look(8'h22, 4'h0);
      wr(OFF_CTRL, 8'h04);
      u_host.strobe(SYN_GHI, b);
      look(8'h22, 4'h1);
      wr(OFF_MASK, 8'h04);
      look(8'h22, 4'h9);
      wr(OFF_EVT, 8'h07);
      look(8'h22, 4'h1);
      $display("test gate and events done");
      print_verdict();
   end
endmodule
`default_nettype wire
